/* design/edge_sync.sv */
// two-flop synchroniser with edge detect on the second stage output
// assumes the input is asynchronous to clk_i
`timescale 1ns/100ps
`default_nettype none
module edge_sync (
  input wire logic clk_i,
  input wire logic rst_n_i,
  input wire logic en_i,
  input wire logic async_i,
  input wire logic reset_val_i,
  output logic level_o,
  output logic rise_o,
  output logic fall_o
);
  logic meta;
  logic stage;
  logic prev;
  always_ff @(posedge clk_i) begin
    if (!rst_n_i) begin
      // reset to the pin's idle level so no false edge follows reset
      meta <= reset_val_i;
      stage <= reset_val_i;
      prev <= reset_val_i;
    end else if (en_i) begin
      meta <= async_i;
      stage <= meta;
      prev <= stage;
    end
  end
  assign level_o = stage;
  assign rise_o = en_i & stage & ~prev;
  assign fall_o = en_i & ~stage & prev;
endmodule
`default_nettype wire

/* design/spi_flash_erase_powerdown_ctrl.sv */
// whole-array erase, deep sleep and wake/signature instruction sequencer
// assumes spi pins arrive asynchronously; sclk far slower than ref_clk_i
// Overview of operation
// - whole erase sets every bit to one, only with write enable latch set
// - write enable opcode sets the write enable latch
// - select must rise right after bit eight, else erase dropped
// - select rise after valid erase starts timed cycle; busy flag high
// - write enable latch cleared some time before erase cycle ends
// - erase runs only when all three protect bits are zero
// - deep sleep only by its opcode; ignores write, program, erase there
// - select high deselects into standby when no cycle runs
// - reset always brings standby, never deep sleep
// - sleep executes only if select rises right after bit eight
// - sleep entered after fixed entry delay from select rise
// - sleep opcode during a busy cycle is rejected
// - wake opcode returns the signature unless a cycle runs
// - wake opcode during busy cycle not decoded, no effect
// - wake opcode then three dummy bytes, signature out on falling edges
// - extra clocks with select low repeat the signature
// - wake after full signature: standby after full wake delay
// - wake cut short before signature: standby after early wake delay
// - reset clears latch and busy flag, device in standby
`timescale 1ns/100ps
`default_nettype none
module spi_flash_erase_powerdown_ctrl
  import flash_ctrl_pkg::*;
#(
  parameter logic [7:0] ERASE_OPCODE = ERASE_OPCODE_DEF,
  parameter logic [7:0] SLEEP_OPCODE = SLEEP_OPCODE_DEF,
  parameter logic [7:0] WAKE_OPCODE = WAKE_OPCODE_DEF,
  parameter logic [7:0] WRITE_ENABLE_OPCODE = WRITE_ENABLE_OPCODE_DEF,
  parameter logic [7:0] SIGNATURE = SIGNATURE_DEF,
  parameter int ERASE_CYCLES = WHOLE_ERASE_CYC
) (
  // clock, reset, enable
  input wire logic ref_clk_i,
  input wire logic rst_n_i,
  input wire logic clk_en_i,
  // spi pins
  input wire spi_pins_t spi_i,
  output logic miso_o,
  output logic miso_oe_o,
  // protection bits, from the status register outside this block
  input wire logic [2:0] protect_level_i,
  // status
  output status_t status_o,
  output logic erase_array_o
);
  typedef enum {ST_IDLE, ST_ERASE, ST_SLEEP_WAIT, ST_SLEEP, ST_WAKE_WAIT} mode_t;
  mode_t mode;

  logic sel_n;
  logic sel_rise;
  logic sel_fall;
  logic sclk_rise;
  logic sclk_fall;
  logic mosi;
  logic [1:0] dummy_fall;

  edge_sync u_sel (.clk_i(ref_clk_i), .rst_n_i(rst_n_i), .en_i(clk_en_i),
    .async_i(spi_i.sel_n), .reset_val_i(1'b1),
    .level_o(sel_n), .rise_o(sel_rise), .fall_o(sel_fall));
  // serial clock idles low between frames
  edge_sync u_sclk (.clk_i(ref_clk_i), .rst_n_i(rst_n_i), .en_i(clk_en_i),
    .async_i(spi_i.sclk), .reset_val_i(1'b0),
    .level_o(), .rise_o(sclk_rise), .fall_o(sclk_fall));
  // data goes through the same two stages so it lines up with the sclk edge
  edge_sync u_mosi (.clk_i(ref_clk_i), .rst_n_i(rst_n_i), .en_i(clk_en_i),
    .async_i(spi_i.mosi), .reset_val_i(1'b0),
    .level_o(mosi), .rise_o(dummy_fall[0]), .fall_o(dummy_fall[1]));

  // bit count and opcode shift, counted within one select-low frame
  logic [5:0] bit_cnt;
  logic [7:0] shift_in;
  logic [7:0] opcode;
  logic frame_active;
  always_ff @(posedge ref_clk_i) begin
    if (!rst_n_i) begin
      bit_cnt <= 6'h00;
      shift_in <= 8'h00;
      opcode <= 8'h00;
      frame_active <= 1'b0;
    end else if (clk_en_i) begin
      if (sel_fall) begin
        bit_cnt <= 6'h00;
        frame_active <= 1'b1;
      end else if (sel_rise) begin
        frame_active <= 1'b0;
      end else if (frame_active && !sel_n && sclk_rise) begin
        shift_in <= {shift_in[6:0], mosi};
        if (bit_cnt == OPCODE_BITS - 6'h01) begin
          opcode <= {shift_in[6:0], mosi};
        end
        if (bit_cnt != 6'h3F) begin
          bit_cnt <= bit_cnt + 6'h01;
        end
      end
    end
  end

  logic exactly_one_byte;
  logic busy;
  logic wake_cmd;
  logic sig_seen;
  assign exactly_one_byte = sel_rise && frame_active && (bit_cnt == OPCODE_BITS);
  assign busy = (mode == ST_ERASE);
  // busy cycle blocks wake decode entirely
  assign wake_cmd = !busy && (bit_cnt >= OPCODE_BITS) && (opcode == WAKE_OPCODE);

  // signature output shifted on falling sclk after the header bits
  logic [2:0] sig_idx;
  always_ff @(posedge ref_clk_i) begin
    if (!rst_n_i) begin
      miso_o <= 1'b0;
      miso_oe_o <= 1'b0;
      sig_idx <= 3'h7;
      sig_seen <= 1'b0;
    end else if (clk_en_i) begin
      if (sel_n || sel_fall) begin
        miso_oe_o <= 1'b0;
        miso_o <= 1'b0;
        sig_idx <= 3'h7;
        if (sel_fall) begin
          sig_seen <= 1'b0;
        end
      end else if (sclk_fall && wake_cmd && bit_cnt >= WAKE_HEADER_BITS) begin
        miso_oe_o <= 1'b1;
        miso_o <= SIGNATURE[sig_idx];
        sig_idx <= sig_idx - 3'h1;
        if (sig_idx == 3'h0) begin
          sig_seen <= 1'b1;
        end
      end
    end
  end

  // write enable latch
  logic write_enable_latch;
  logic erase_go;
  logic sleep_go;
  logic latch_set;
  assign erase_go = exactly_one_byte && opcode == ERASE_OPCODE && mode == ST_IDLE
    && write_enable_latch && protect_level_i == PROTECT_RESET;
  assign sleep_go = exactly_one_byte && opcode == SLEEP_OPCODE && mode == ST_IDLE;
  // only idle accepts it, so sleep also shuts out the write enable opcode
  assign latch_set = exactly_one_byte && opcode == WRITE_ENABLE_OPCODE
    && mode == ST_IDLE;

  int unsigned cnt;
  always_ff @(posedge ref_clk_i) begin
    if (!rst_n_i) begin
      write_enable_latch <= 1'b0;
    end else if (clk_en_i) begin
      if (latch_set) begin
        write_enable_latch <= 1'b1;
      end else if (mode == ST_ERASE && cnt == LATCH_CLEAR_CYC) begin
        write_enable_latch <= 1'b0;
      end
    end
  end

  // mode sequencer and delay counter
  always_ff @(posedge ref_clk_i) begin
    if (!rst_n_i) begin
      mode <= ST_IDLE;
      cnt <= 0;
      erase_array_o <= 1'b0;
    end else if (clk_en_i) begin
      erase_array_o <= 1'b0;
      unique case (mode)
        ST_IDLE: begin
          if (erase_go) begin
            mode <= ST_ERASE;
            cnt <= 0;
          end else if (sleep_go) begin
            mode <= ST_SLEEP_WAIT;
            cnt <= 0;
          end
        end
        ST_ERASE: begin
          if (cnt >= ERASE_CYCLES - 1) begin
            mode <= ST_IDLE;
            erase_array_o <= 1'b1;
          end else begin
            cnt <= cnt + 1;
          end
        end
        ST_SLEEP_WAIT: begin
          if (cnt >= SLEEP_ENTRY_CYC - 1) begin
            mode <= ST_SLEEP;
          end else begin
            cnt <= cnt + 1;
          end
        end
        ST_SLEEP: begin
          if (sel_rise && frame_active && bit_cnt >= OPCODE_BITS
              && opcode == WAKE_OPCODE) begin
            mode <= ST_WAKE_WAIT;
            cnt <= sig_seen ? (EARLY_WAKE_CYC - FULL_WAKE_CYC) : 0;
          end
        end
        ST_WAKE_WAIT: begin
          if (cnt >= EARLY_WAKE_CYC - 1) begin
            mode <= ST_IDLE;
          end else begin
            cnt <= cnt + 1;
          end
        end
      endcase
    end
  end

  always_ff @(posedge ref_clk_i) begin
    if (!rst_n_i) begin
      status_o <= '0;
    end else if (clk_en_i) begin
      status_o.write_enable_latch <= write_enable_latch;
      status_o.write_in_progress <= busy;
      status_o.deep_sleep <= (mode == ST_SLEEP) || (mode == ST_WAKE_WAIT);
    end
  end

  // assertions
  property p_erase_needs_latch;
    @(posedge ref_clk_i) disable iff (!rst_n_i)
      (mode == ST_IDLE && $past(mode) == ST_IDLE ##1 mode == ST_ERASE)
        |-> $past(write_enable_latch, 1);
  endproperty
  a_erase_needs_latch: assert property (p_erase_needs_latch) else $error("erase without latch");

  property p_latch_set;
    @(posedge ref_clk_i) disable iff (!rst_n_i) (clk_en_i && latch_set) |=> write_enable_latch;
  endproperty
  a_latch_set: assert property (p_latch_set) else $error("latch not set");

  property p_busy_flag;
    @(posedge ref_clk_i) disable iff (!rst_n_i) (clk_en_i && erase_go) |=> ##1 status_o.write_in_progress || !clk_en_i;
  endproperty
  a_busy_flag: assert property (p_busy_flag) else $error("busy flag missing");

  property p_protect;
    @(posedge ref_clk_i) disable iff (!rst_n_i)
      (mode == ST_IDLE && protect_level_i != 3'h0) |=> mode != ST_ERASE;
  endproperty
  a_protect: assert property (p_protect) else $error("protected erase ran");

  property p_latch_clear;
    @(posedge ref_clk_i) disable iff (!rst_n_i)
      (mode == ST_ERASE && $past(mode) == ST_ERASE && !latch_set ##1 mode == ST_IDLE)
        |-> !write_enable_latch;
  endproperty
  a_latch_clear: assert property (p_latch_clear) else $error("latch survived erase");

  property p_sleep_reject;
    @(posedge ref_clk_i) disable iff (!rst_n_i) busy |=> mode != ST_SLEEP_WAIT;
  endproperty
  a_sleep_reject: assert property (p_sleep_reject) else $error("sleep during erase");

  property p_wake_quiet;
    @(posedge ref_clk_i) disable iff (!rst_n_i) busy |-> !miso_oe_o;
  endproperty
  a_wake_quiet: assert property (p_wake_quiet) else $error("signature during erase");

  property p_sleep_entry;
    @(posedge ref_clk_i) disable iff (!rst_n_i)
      (mode == ST_IDLE ##1 mode == ST_SLEEP_WAIT) |-> mode != ST_SLEEP [*2];
  endproperty
  a_sleep_entry: assert property (p_sleep_entry) else $error("sleep entered too soon");

  // busy flag must fall right after the array pulse
  property p_erase_done;
    @(posedge ref_clk_i) disable iff (!rst_n_i)
      (clk_en_i && erase_array_o) |=> !status_o.write_in_progress || !clk_en_i;
  endproperty
  a_erase_done: assert property (p_erase_done) else $error("busy after erase");

  property p_sleep_by_opcode;
    @(posedge ref_clk_i) disable iff (!rst_n_i)
      (mode == ST_SLEEP && $past(mode) != ST_SLEEP) |-> $past(mode) == ST_SLEEP_WAIT;
  endproperty
  a_sleep_by_opcode: assert property (p_sleep_by_opcode) else $error("sleep without opcode");

  property p_no_latch_in_sleep;
    @(posedge ref_clk_i) disable iff (!rst_n_i)
      (mode == ST_SLEEP && !write_enable_latch) |=> !write_enable_latch;
  endproperty
  a_no_latch_in_sleep: assert property (p_no_latch_in_sleep) else $error("latch set in sleep");

  property p_sleep_from_idle;
    @(posedge ref_clk_i) disable iff (!rst_n_i)
      (mode == ST_SLEEP_WAIT && $past(mode) != ST_SLEEP_WAIT) |-> $past(mode) == ST_IDLE;
  endproperty
  a_sleep_from_idle: assert property (p_sleep_from_idle) else $error("sleep from busy");

  // the driver is released one cycle after select is seen high
  property p_oe_selected;
    @(posedge ref_clk_i) disable iff (!rst_n_i) miso_oe_o |-> $past(!sel_n);
  endproperty
  a_oe_selected: assert property (p_oe_selected) else $error("output while deselected");

  property p_wake_exit;
    @(posedge ref_clk_i) disable iff (!rst_n_i)
      mode == ST_WAKE_WAIT |=> (mode == ST_WAKE_WAIT || mode == ST_IDLE);
  endproperty
  a_wake_exit: assert property (p_wake_exit) else $error("wake left to wrong mode");

  // checked through reset itself, so no disable here
  property p_reset_standby;
    @(posedge ref_clk_i) !rst_n_i |=> (mode == ST_IDLE && !write_enable_latch);
  endproperty
  a_reset_standby: assert property (p_reset_standby) else $error("reset not standby");

  c_erase: cover property (@(posedge ref_clk_i) mode == ST_ERASE);
  c_erase_done: cover property (@(posedge ref_clk_i) erase_array_o);
  c_sleep: cover property (@(posedge ref_clk_i) mode == ST_SLEEP);
  c_wake: cover property (@(posedge ref_clk_i) mode == ST_WAKE_WAIT ##1 mode == ST_IDLE);
  c_sig: cover property (@(posedge ref_clk_i) sig_seen);
endmodule
`default_nettype wire

/* inc/flash_ctrl_pkg.sv */
// constants and carrier types for the erase / sleep / wake sequencer
// assumes a 20 MHz core clock; spi pins are asynchronous to it
`default_nettype none
package flash_ctrl_pkg;
  localparam int CLK_NS = 50;
  localparam int BITS_PER_BYTE = 8;
  localparam logic [5:0] OPCODE_BITS = 6'h08;
  localparam logic [5:0] WAKE_HEADER_BITS = 6'h20;
  // default opcodes, arbitrary values, overridable per instance
  localparam logic [7:0] ERASE_OPCODE_DEF = 8'h3C;
  localparam logic [7:0] SLEEP_OPCODE_DEF = 8'h5D;
  localparam logic [7:0] WAKE_OPCODE_DEF = 8'h6E;
  localparam logic [7:0] WRITE_ENABLE_OPCODE_DEF = 8'h12;
  // arbitrary neutral signature value
  localparam logic [7:0] SIGNATURE_DEF = 8'h5A;
  // times in microseconds, plain defaults
  localparam int WHOLE_ERASE_TIME_US = 1000;
  localparam int SLEEP_ENTRY_DELAY_US = 3;
  localparam int EARLY_WAKE_DELAY_US = 3;
  localparam int FULL_WAKE_DELAY_US = 2;
  localparam int WHOLE_ERASE_CYC = (WHOLE_ERASE_TIME_US * 1000) / CLK_NS;
  localparam int SLEEP_ENTRY_CYC = (SLEEP_ENTRY_DELAY_US * 1000) / CLK_NS;
  localparam int EARLY_WAKE_CYC = (EARLY_WAKE_DELAY_US * 1000) / CLK_NS;
  localparam int FULL_WAKE_CYC = (FULL_WAKE_DELAY_US * 1000) / CLK_NS;
  localparam int LATCH_CLEAR_CYC = 2;
  localparam logic [2:0] PROTECT_RESET = 3'h0;

  typedef struct packed {
    logic sel_n;
    logic sclk;
    logic mosi;
  } spi_pins_t;

  typedef struct packed {
    logic write_enable_latch;
    logic write_in_progress;
    logic deep_sleep;
  } status_t;
endpackage
`default_nettype wire

/* testbench/spi_host_model.sv */
// spi host model: drives select, serial clock and data toward the flash block
// assumes the bench clock; one serial clock lasts 8 ref clocks (400 ns)
`timescale 1ns/100ps
`default_nettype none
module spi_host_model
  import flash_ctrl_pkg::*;
(
  // clock
  input wire logic ref_clk_i,
  // spi pins
  output var spi_pins_t spi_o,
  input wire logic miso_i
);
  initial begin
    spi_o = 3'h4;
  end

  task automatic half();
    repeat (4) @(negedge ref_clk_i);
  endtask

  // opcode then zero filler bits; miso is sampled just before each rise past bit 32
  task automatic run(input logic [7:0] op, input int n, output logic [15:0] got);
    got = 16'h0000;
    spi_o.sel_n = 1'b0;
    half();
    for (int i = 0; i < n; i++) begin
      spi_o.mosi = (i < 8) ? op[7 - i] : 1'b0;
      half();
      if (i >= 32) begin
        got = {got[14:0], miso_i};
      end
      spi_o.sclk = 1'b1;
      half();
      spi_o.sclk = 1'b0;
    end
    half();
    spi_o.sel_n = 1'b1;
    // data line is not held once deselected
    spi_o.mosi = ~spi_o.mosi;
  endtask
endmodule
`default_nettype wire

/* testbench/test_spi_flash_erase_powerdown_ctrl.sv */
// self-checking bench for the erase / sleep / wake sequencer
// assumes a shortened erase count; the host model makes the serial traffic
`timescale 1ns/100ps
`default_nettype none
module test_spi_flash_erase_powerdown_ctrl;
  import flash_ctrl_pkg::*;
  localparam int ERASE_CYC = 2000;
  logic ref_clk_i;
  logic rst_n_i;
  spi_pins_t spi;
  logic miso;
  logic miso_oe;
  logic [2:0] protect;
  status_t status;
  logic erase_pulse;
  logic erase_seen;
  logic oe_seen;
  logic [15:0] got;
  int bad_count = 0;
  int n_compared = 0;
  int cycles = 0;

  initial begin
    ref_clk_i = 1'b0;
    forever #25 ref_clk_i = ~ref_clk_i;
  end

  spi_flash_erase_powerdown_ctrl #(.ERASE_CYCLES(ERASE_CYC)) spi_flash_erase_powerdown_ctrl_inst (
    .ref_clk_i(ref_clk_i), .rst_n_i(rst_n_i), .clk_en_i(1'b1), .spi_i(spi),
    .miso_o(miso), .miso_oe_o(miso_oe), .protect_level_i(protect),
    .status_o(status), .erase_array_o(erase_pulse));

  spi_host_model spi_host_model_inst (.ref_clk_i(ref_clk_i), .spi_o(spi), .miso_i(miso));

  always @(posedge ref_clk_i) begin
    cycles++;
    if (erase_pulse) erase_seen <= 1'b1;
    if (miso_oe) oe_seen <= 1'b1;
    if (cycles == 20000) begin
      bad_count++;
      close_out();
    end
  end

  task automatic close_out();
    $display("tests done: %0d compared, %0d bad", n_compared, bad_count);
    if (bad_count == 0 && n_compared > 0) $display("Finished cleanly");
    else $display("Finished with errors");
    $finish;
  endtask

  task automatic cmp(input logic [15:0] g, input logic [15:0] e, input string what);
    n_compared++;
    if (g !== e) begin
      bad_count++;
      $display("[ERR] t=%0t %s got=%h exp=%h", $time, what, g, e);
    end
  endtask

  task automatic settle(input int n);
    repeat (n) @(negedge ref_clk_i);
  endtask

  // status bits: 2 latch, 1 busy, 0 sleep
  task automatic wait_flag(input int idx, input logic val, input int lim);
    int k;
    k = 0;
    while (status[idx] !== val && k < lim) begin
      @(negedge ref_clk_i);
      k++;
    end
    cmp(status[idx], val, "status flag");
  endtask

  task automatic t_erase();
    spi_host_model_inst.run(ERASE_OPCODE_DEF, 8, got);
    settle(20);
    cmp(status.write_in_progress, 1'b0, "erase without latch");
    spi_host_model_inst.run(WRITE_ENABLE_OPCODE_DEF, 8, got);
    wait_flag(2, 1'b1, 20);
    protect = 3'h4;
    spi_host_model_inst.run(ERASE_OPCODE_DEF, 8, got);
    settle(20);
    cmp(status.write_in_progress, 1'b0, "protected erase");
    protect = 3'h0;
    spi_host_model_inst.run(ERASE_OPCODE_DEF, 9, got);
    settle(20);
    cmp(status.write_in_progress, 1'b0, "nine bit erase");
    cmp(erase_seen, 1'b0, "no array erase yet");
    spi_host_model_inst.run(ERASE_OPCODE_DEF, 8, got);
    wait_flag(1, 1'b1, 10);
    spi_host_model_inst.run(SLEEP_OPCODE_DEF, 8, got);
    settle(SLEEP_ENTRY_CYC + 20);
    cmp({status.deep_sleep, status.write_in_progress}, 2'h1, "sleep while busy");
    oe_seen = 1'b0;
    spi_host_model_inst.run(WAKE_OPCODE_DEF, 48, got);
    cmp(oe_seen, 1'b0, "wake while busy");
    wait_flag(1, 1'b0, ERASE_CYC);
    cmp(status.write_enable_latch, 1'b0, "latch after erase");
    cmp(erase_seen, 1'b1, "array erased");
    $display("test erase done");
  endtask

  task automatic t_wake();
    oe_seen = 1'b0;
    spi_host_model_inst.run(WAKE_OPCODE_DEF, 48, got);
    cmp(got, {SIGNATURE_DEF, SIGNATURE_DEF}, "signature twice");
    cmp(oe_seen, 1'b1, "output driven");
    settle(4);
    cmp({miso_oe, status.deep_sleep}, 2'h0, "standby after wake");
    $display("test wake done");
  endtask

  task automatic t_sleep();
    spi_host_model_inst.run(SLEEP_OPCODE_DEF, 9, got);
    settle(SLEEP_ENTRY_CYC + 20);
    cmp(status.deep_sleep, 1'b0, "nine bit sleep");
    spi_host_model_inst.run(SLEEP_OPCODE_DEF, 8, got);
    settle(SLEEP_ENTRY_CYC - 10);
    cmp(status.deep_sleep, 1'b0, "entry delay");
    wait_flag(0, 1'b1, 30);
    spi_host_model_inst.run(WRITE_ENABLE_OPCODE_DEF, 8, got);
    settle(20);
    cmp(status.write_enable_latch, 1'b0, "latch in sleep");
    spi_host_model_inst.run(WAKE_OPCODE_DEF, 8, got);
    settle(EARLY_WAKE_CYC - 10);
    cmp(status.deep_sleep, 1'b1, "early wake delay");
    wait_flag(0, 1'b0, 30);
    spi_host_model_inst.run(SLEEP_OPCODE_DEF, 8, got);
    wait_flag(0, 1'b1, SLEEP_ENTRY_CYC + 20);
    spi_host_model_inst.run(WAKE_OPCODE_DEF, 40, got);
    cmp(got[7:0], SIGNATURE_DEF, "signature from sleep");
    wait_flag(0, 1'b0, FULL_WAKE_CYC + 20);
    $display("test sleep done");
  endtask

  initial begin
    rst_n_i = 1'b0;
    protect = 3'h0;
    erase_seen = 1'b0;
    oe_seen = 1'b0;
    got = 16'h0000;
    settle(12);
    rst_n_i = 1'b1;
    settle(4);
    cmp({status, miso_oe, erase_pulse}, 5'h00, "reset state");
    $display("test reset done");
    t_erase();
    t_wake();
    t_sleep();
    close_out();
  end
endmodule
`default_nettype wire
